/* File: hw/aux_regs_pkg.sv */
`default_nettype none
package aux_regs_pkg;
    // ************************************************************
    // Secondary register pointers
    // ************************************************************
    localparam logic [3:0] PTR_MATCH   = 4'h8;
    localparam logic [3:0] PTR_SYNC    = 4'h9;
    localparam logic [3:0] PTR_MAINT   = 4'hA;
    localparam logic [3:0] PTR_CHK_RX  = 4'hD;
    localparam logic [3:0] PTR_CHK_TX  = 4'hE;
    localparam logic [3:0] PTR_POLY    = 4'hF;
    // ************************************************************
    // Pointer field in the primary pointer/error register
    // ************************************************************
    localparam int PTR_LSB = 8;
    localparam int PTR_MSB = 11;
    // ************************************************************
    // Maintenance register fields
    // ************************************************************
    localparam int MC_SHIFT_CLK = 0;
    localparam int MC_STEP      = 1;
    localparam int MC_UNUSED    = 2;
    localparam int MC_LOOP      = 3;
    localparam int MC_FORCE_RX  = 4;
    localparam int MC_CLEAR     = 5;
    localparam int MC_HIGH_HALF = 6;
    localparam int MC_SEND_BIT  = 7;
    // ************************************************************
    // Reset values and sizes
    // ************************************************************
    localparam logic [15:0] SYNC_RESET  = 16'h0000;
    localparam logic [15:0] MATCH_RESET = 16'h0000;
    localparam int          MATCH_DEPTH = 16;
    // ************************************************************
    // Bit clock source selection
    // ************************************************************
    typedef enum logic [1:0] {
        CLK_SRC_MODEM,
        CLK_SRC_OSC,
        CLK_SRC_SOFT
    } clk_src_t;
endpackage : aux_regs_pkg
`default_nettype wire

/* File: hw/sync_line_aux_registers.sv */
`default_nettype none
module sync_line_aux_registers
    import aux_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // Primary pointer/error register write
    input  wire logic                ptr_wr,
    input  wire logic [15:0]         ptr_wdata,
    // Indirect data port
    input  wire logic                data_wr,
    input  wire logic                data_rd,
    input  wire logic [15:0]         data_wdata,
    output logic      [15:0]         data_rdata,
    output logic      [3:0]          reg_ptr,
    // Check value and polynomial halves from the engines
    input  wire logic [23:0]         chk_rx_val,
    input  wire logic [23:0]         chk_tx_val,
    input  wire logic [23:0]         poly_val,
    // Serial engine status
    input  wire logic                tx_lsb,
    input  wire logic                tx_active,
    input  wire logic                rx_active,
    // Controls to the engines
    output logic                     soft_shift_tx,
    output logic                     soft_strobe_rx,
    output aux_regs_pkg::clk_src_t   bit_clk_src,
    output logic                     loopback,
    output logic                     loop_rx_bit,
    output logic                     force_rx_xfer,
    output logic                     force_rx_from_shift,
    output logic                     master_clear,
    output logic                     high_half_sel,
    output logic                     pair_sel_align,
    output logic                     strap_chars_off,
    // Match table lookup
    input  wire logic [3:0]          match_idx,
    output logic      [15:0]         match_entry,
    output logic      [15:0]         sync_pattern
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [MATCH_DEPTH-1:0][15:0] match;
        logic [15:0]                  sync;
        logic [3:0]                   ptr;
        logic                         shift_clk;
        logic                         step;
        logic                         loop;
        logic                         high_half;
        logic                         send_bit;
        logic                         shift_tx;
        logic                         strobe_rx;
        logic                         force_rx;
        logic                         force_src;
        logic                         mclr;
        logic [15:0]                  rdata;
        logic [15:0]                  entry;
        clk_src_t                     src;
        logic                         loop_bit;
        logic                         strap;
        logic                         align;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic   clr;
    logic   wr_maint;
    logic   [15:0] maint_rd;
    logic   [23:0] half_src;
    logic   [MATCH_DEPTH-1:0] match_we;

    // ************************************************************
    // Match entry write enables
    // ************************************************************
    for (genvar e = 0; e < MATCH_DEPTH; e++)
    begin : g_match_we
        assign match_we[e] = data_wr && (s_q.ptr == PTR_MATCH) && (match_idx == 4'(e));
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_d       = s_q;
        clr       = sys_rst || s_q.mclr;
        wr_maint  = data_wr && (s_q.ptr == PTR_MAINT);
        s_d.force_rx  = 1'b0;
        s_d.mclr      = 1'b0;
        s_d.shift_tx  = 1'b0;
        s_d.strobe_rx = 1'b0;

        // ********************************************************
        // Pointer
        // ********************************************************
        if (ptr_wr)
        begin
            s_d.ptr = ptr_wdata[PTR_MSB:PTR_LSB];
        end

        // ********************************************************
        // Match table
        // ********************************************************
        for (int e = 0; e < MATCH_DEPTH; e++)
        begin
            if (match_we[e])
            begin
                s_d.match[e] = data_wdata;
            end
        end

        // ********************************************************
        // Sync pattern
        // ********************************************************
        if (data_wr && (s_q.ptr == PTR_SYNC))
        begin
            s_d.sync = data_wdata;
        end

        // ********************************************************
        // Maintenance writes
        // ********************************************************
        if (wr_maint)
        begin
            s_d.shift_clk = data_wdata[MC_SHIFT_CLK];
            s_d.step      = data_wdata[MC_STEP];
            s_d.loop      = data_wdata[MC_LOOP];
            s_d.high_half = data_wdata[MC_HIGH_HALF];
            if (!tx_active && s_q.loop)
            begin
                s_d.send_bit = data_wdata[MC_SEND_BIT];
            end
            s_d.force_rx  = data_wdata[MC_FORCE_RX];
            s_d.force_src = !rx_active;
            s_d.mclr      = data_wdata[MC_CLEAR];
            if (data_wdata[MC_SHIFT_CLK] && !s_q.shift_clk)
            begin
                s_d.shift_tx = 1'b1;
            end
            if (!data_wdata[MC_SHIFT_CLK] && s_q.shift_clk)
            begin
                s_d.strobe_rx = 1'b1;
            end
        end

        // ********************************************************
        // Send bit
        // ********************************************************
        if (!(s_q.loop && !tx_active))
        begin
            s_d.send_bit = tx_lsb;
        end
        s_d.loop_bit = s_d.send_bit;

        // ********************************************************
        // Bit clock source
        // ********************************************************
        if (s_d.step)
        begin
            s_d.src = CLK_SRC_SOFT;
        end
        else if (s_d.loop)
        begin
            s_d.src = CLK_SRC_OSC;
        end
        else
        begin
            s_d.src = CLK_SRC_MODEM;
        end

        // ********************************************************
        // Initialize and master clear
        // ********************************************************
        if (clr)
        begin
            s_d.sync      = SYNC_RESET;
            s_d.shift_clk = 1'b0;
            s_d.step      = 1'b0;
            s_d.loop      = 1'b0;
            s_d.high_half = 1'b0;
            s_d.src       = CLK_SRC_MODEM;
            s_d.shift_tx  = 1'b0;
            s_d.strobe_rx = 1'b0;
            s_d.force_rx  = 1'b0;
        end
        if (sys_rst)
        begin
            s_d.ptr  = 4'h0;
            s_d.mclr = 1'b0;
        end

        // ********************************************************
        // Read data
        // ********************************************************
        maint_rd = 16'h0000;
        maint_rd[MC_SHIFT_CLK] = s_q.shift_clk;
        maint_rd[MC_STEP]      = s_q.step;
        maint_rd[MC_LOOP]      = s_q.loop;
        maint_rd[MC_HIGH_HALF] = s_q.high_half;
        maint_rd[MC_SEND_BIT]  = s_q.send_bit;
        half_src = 24'h000000;
        unique case (s_q.ptr)
            PTR_CHK_RX:
            begin
                half_src = chk_rx_val;
            end
            PTR_CHK_TX:
            begin
                half_src = chk_tx_val;
            end
            PTR_POLY:
            begin
                half_src = poly_val;
            end
            default:
            begin
                half_src = 24'h000000;
            end
        endcase
        s_d.rdata = s_q.rdata;
        if (data_rd)
        begin
            unique case (s_q.ptr)
                PTR_MATCH:
                begin
                    s_d.rdata = s_q.match[match_idx];
                end
                PTR_SYNC:
                begin
                    s_d.rdata = s_q.sync;
                end
                PTR_MAINT:
                begin
                    s_d.rdata = maint_rd;
                end
                PTR_CHK_RX,
                PTR_CHK_TX,
                PTR_POLY:
                begin
                    s_d.rdata = s_q.high_half ? {8'h00, half_src[23:16]} : half_src[15:0];
                end
                default:
                begin
                    s_d.rdata = 16'h0000;
                end
            endcase
        end

        // ********************************************************
        // Lookup and status
        // ********************************************************
        s_d.entry = s_q.match[match_idx];
        s_d.strap = 1'b1;
        s_d.align = s_d.mclr;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_q       <= '0;
            s_q.match <= s_d.match;
            s_q.align <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb
    begin

        // ********************************************************
        // Host side
        // ********************************************************
        data_rdata          = s_q.rdata;
        reg_ptr             = s_q.ptr;

        // ********************************************************
        // Engine controls
        // ********************************************************
        soft_shift_tx       = s_q.shift_tx;
        soft_strobe_rx      = s_q.strobe_rx;
        bit_clk_src         = s_q.src;
        loopback            = s_q.loop;
        loop_rx_bit         = s_q.loop_bit;
        force_rx_xfer       = s_q.force_rx;
        force_rx_from_shift = s_q.force_src;
        master_clear        = s_q.mclr;
        high_half_sel       = s_q.high_half;
        pair_sel_align      = s_q.align;
        strap_chars_off     = s_q.strap;

        // ********************************************************
        // Lookup
        // ********************************************************
        match_entry         = s_q.entry;
        sync_pattern        = s_q.sync;
    end
endmodule : sync_line_aux_registers
`default_nettype wire

/* File: bench/aux_regs_sva.sv */
`default_nettype none
module aux_regs_chk
(
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   sys_rst,
    // Host side
    input wire logic                   ptr_wr,
    input wire logic [15:0]            ptr_wdata,
    input wire logic                   data_wr,
    input wire logic                   data_rd,
    input wire logic [15:0]            data_wdata,
    input wire logic [15:0]            data_rdata,
    input wire logic [3:0]             reg_ptr,
    // Engine side
    input wire logic [23:0]            poly_val,
    input wire logic                   rx_active,
    input wire logic                   soft_shift_tx,
    input wire logic                   soft_strobe_rx,
    input wire aux_regs_pkg::clk_src_t bit_clk_src,
    input wire logic                   loopback,
    input wire logic                   force_rx_xfer,
    input wire logic                   force_rx_from_shift,
    input wire logic                   master_clear,
    input wire logic                   pair_sel_align,
    input wire logic                   high_half_sel,
    input wire logic                   strap_chars_off
);
    import aux_regs_pkg::*;
    wire logic mw = data_wr && reg_ptr == PTR_MAINT;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_ptr_load: assert property (ptr_wr |=> reg_ptr == $past(ptr_wdata[11:8]))
        else $error("pointer not loaded");
    chk_shift_rise: assert property (soft_shift_tx |-> $past(mw) && $past(data_wdata[0]))
        else $error("shift pulse without set write");
    chk_strobe_fall: assert property (soft_strobe_rx |-> $past(mw) && !$past(data_wdata[0]))
        else $error("strobe pulse without clear write");
    chk_force_source: assert property (mw && data_wdata[4] && !data_wdata[5]
        |=> force_rx_xfer && force_rx_from_shift == !$past(rx_active))
        else $error("forced transfer wrong");
    chk_force_cause: assert property (force_rx_xfer |-> $past(mw) && $past(data_wdata[4]))
        else $error("forced transfer without write");
    chk_clear_pulse: assert property (mw && data_wdata[5] |=> master_clear && pair_sel_align)
        else $error("master clear missing");
    chk_clock_source: assert property (bit_clk_src != CLK_SRC_SOFT |-> (bit_clk_src == CLK_SRC_OSC) == loopback)
        else $error("clock source wrong");
    chk_maint_zeros: assert property (data_rd && reg_ptr == PTR_MAINT |=> data_rdata[5:4] == 2'h0 && !data_rdata[2])
        else $error("maintenance read bits not zero");
    chk_high_half: assert property (data_rd && reg_ptr == PTR_POLY && high_half_sel
        |=> data_rdata == {8'h00, $past(poly_val[23:16])})
        else $error("polynomial high half wrong");
    chk_strap_off: assert property (!$past(sys_rst) |-> strap_chars_off)
        else $error("strapped characters not disabled");
    cover property (master_clear);
    cover property (force_rx_xfer && force_rx_from_shift);
    cover property (data_rd && reg_ptr == PTR_POLY && high_half_sel);
endmodule : aux_regs_chk
bind sync_line_aux_registers aux_regs_chk u_chk (.clk, .sys_rst, .ptr_wr, .ptr_wdata, .data_wr, .data_rd,
    .data_wdata, .data_rdata, .reg_ptr, .poly_val, .rx_active, .soft_shift_tx, .soft_strobe_rx, .bit_clk_src,
    .loopback, .force_rx_xfer, .force_rx_from_shift, .master_clear, .pair_sel_align, .high_half_sel,
    .strap_chars_off);
`default_nettype wire

/* File: bench/sync_line_aux_registers_test.sv */
`default_nettype none
module sync_line_aux_registers_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aux_regs_pkg::*;
    logic        clk, ptr_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0, sys_rst = 1'b1;
    logic        tx_lsb = 1'b1, tx_active = 1'b1, rx_active = 1'b0;
    logic [15:0] ptr_wdata = 16'h0000, data_wdata = 16'h0000, data_rdata, match_entry, sync_pattern;
    logic [23:0] chk_rx_val = 24'h123456, chk_tx_val = 24'h789ABC, poly_val = 24'hDEF012;
    logic [3:0]  match_idx = 4'h0, reg_ptr;
    logic        soft_shift_tx, soft_strobe_rx, loopback, loop_rx_bit, force_rx_xfer, force_rx_from_shift;
    logic        master_clear, high_half_sel, pair_sel_align, strap_chars_off;
    clk_src_t    bit_clk_src;
    int          mismatches = 0, cmp_count = 0;
    sync_line_aux_registers DUT (.clk, .sys_rst, .ptr_wr, .ptr_wdata, .data_wr, .data_rd, .data_wdata,
        .data_rdata, .reg_ptr, .chk_rx_val, .chk_tx_val, .poly_val, .tx_lsb, .tx_active, .rx_active,
        .soft_shift_tx, .soft_strobe_rx, .bit_clk_src, .loopback, .loop_rx_bit, .force_rx_xfer,
        .force_rx_from_shift, .master_clear, .high_half_sel, .pair_sel_align, .strap_chars_off,
        .match_idx, .match_entry, .sync_pattern);
    // ************************************************************
    // Access and compare tasks
    // ************************************************************
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk
    task acc(input logic [3:0] p, input logic w, input logic [15:0] d);
        @(posedge clk);
        ptr_wr    <= 1'b1;
        ptr_wdata <= {4'h0, p, 8'h00};
        @(posedge clk);
        ptr_wr     <= 1'b0;
        data_wr    <= w;
        data_rd    <= !w;
        data_wdata <= d;
        @(posedge clk);
        data_wr <= 1'b0;
        data_rd <= 1'b0;
        #1;
    endtask : acc
    task rd(input logic [3:0] p, input logic [15:0] exp, input string what);
        acc(p, 1'b0, 16'h0000);
        chk(data_rdata, exp, what);
    endtask : rd
    task rdm(input logic [7:0] exp);
        acc(PTR_MAINT, 1'b0, 16'h0000);
        chk({8'h00, data_rdata[7:0]}, {8'h00, exp}, "maintenance");
    endtask : rdm
    function logic [15:0] mv(input int i);
        return {4'h0, i[3:0], 4'h0, ~i[3:0]};
    endfunction : mv
    function logic [15:0] hf(input logic [23:0] v, input int h);
        return h != 0 ? {8'h00, v[23:16]} : v[15:0];
    endfunction : hf
    task stop_test;
        $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // ************************************************************
    // Clock, watchdog and tests
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        mismatches++;
        stop_test;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(PTR_SYNC, 16'h0000, "sync after reset");
        rdm(8'h80);
        chk(bit_clk_src, CLK_SRC_MODEM, "clock source");
        chk(strap_chars_off, 1'b1, "strap disable");
        for (int i = 0; i < 16; i++)
        begin
            match_idx <= i[3:0];
            acc(PTR_MATCH, 1'b1, mv(i));
        end
        for (int i = 15; i >= 0; i--)
        begin
            match_idx <= i[3:0];
            rd(PTR_MATCH, mv(i), "match read");
            chk(match_entry, mv(i), "match entry");
        end
        acc(PTR_SYNC, 1'b1, 16'h5A5A);
        rd(PTR_SYNC, 16'h5A5A, "sync read");
        chk(sync_pattern, 16'h5A5A, "sync port");
        acc(PTR_MAINT, 1'b1, 16'h000F);
        chk(soft_shift_tx, 1'b1, "shift pulse");
        chk(loopback, 1'b1, "loopback");
        chk(bit_clk_src, CLK_SRC_SOFT, "clock source");
        rdm(8'h8B);
        acc(PTR_MAINT, 1'b1, 16'h000A);
        chk(soft_strobe_rx, 1'b1, "strobe pulse");
        acc(PTR_MAINT, 1'b1, 16'h0008);
        chk(bit_clk_src, CLK_SRC_OSC, "clock source");
        tx_active <= 1'b0;
        tx_lsb    <= 1'b0;
        acc(PTR_MAINT, 1'b1, 16'h0088);
        rdm(8'h88);
        chk(loop_rx_bit, 1'b1, "loop bit");
        tx_active <= 1'b1;
        tx_lsb    <= 1'b1;
        acc(PTR_MAINT, 1'b1, 16'h0000);
        chk(bit_clk_src, CLK_SRC_MODEM, "clock source");
        for (int a = 0; a < 2; a++)
        begin
            rx_active <= a[0];
            acc(PTR_MAINT, 1'b1, 16'h0010);
            chk(force_rx_xfer, 1'b1, "forced transfer");
            chk(force_rx_from_shift, !a[0], "transfer source");
            rdm(8'h80);
        end
        for (int h = 1; h >= 0; h--)
        begin
            acc(PTR_MAINT, 1'b1, {9'h000, h[0], 6'h00});
            chk(high_half_sel, h[0], "half select");
            rd(PTR_CHK_RX, hf(chk_rx_val, h), "receive check");
            rd(PTR_CHK_TX, hf(chk_tx_val, h), "transmit check");
            rd(PTR_POLY, hf(poly_val, h), "polynomial");
        end
        acc(PTR_SYNC, 1'b1, 16'h1234);
        acc(PTR_MAINT, 1'b1, 16'h004B);
        acc(PTR_MAINT, 1'b1, 16'h006B);
        chk(master_clear, 1'b1, "master clear");
        chk(pair_sel_align, 1'b1, "pair align");
        rd(PTR_SYNC, 16'h0000, "sync after clear");
        rdm(8'h80);
        chk(bit_clk_src, CLK_SRC_MODEM, "clock source after clear");
        match_idx <= 4'h5;
        rd(PTR_MATCH, mv(5), "match after clear");
        acc(PTR_SYNC, 1'b1, 16'h1234);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(PTR_SYNC, 16'h0000, "sync after reset");
        rd(PTR_MATCH, mv(5), "match after reset");
        acc(4'h3, 1'b1, 16'hFFFF);
        rd(4'h3, 16'h0000, "unused pointer");
        chk(reg_ptr, 16'h0003, "pointer");
        stop_test;
    end
endmodule : sync_line_aux_registers_test
`default_nettype wire
